// ---- qtm_pkg.sv ----
// constants for the quad timer mode-control block
`default_nettype none
package qtm_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_TM0 = 12'h0D0;
	localparam logic [11:0] IDX_TM1 = 12'h0D2;
	localparam logic [11:0] IDX_TM2 = 12'h0D6;
	localparam logic [11:0] IDX_TM3 = 12'h0D8;
	localparam logic [11:0] IDX_CNT0 = 12'h0E0;
	localparam logic [11:0] IDX_DUTY = 12'h0E4;
	// field positions
	localparam int ST_BIT = 0;
	localparam int CN_BIT = 1;
	localparam int CK_LSB = 2;
	localparam int PWMEN_BIT = 5;
	localparam int CAS_BIT = 6;
	localparam int POL_BIT = 7;
	// writable bits and reset values
	localparam logic [7:0] EVEN_MASK = 8'h3F;
	localparam logic [7:0] TM1_MASK = 8'h4F;
	localparam logic [7:0] TM3_MASK = 8'hEF;
	localparam logic [7:0] REG_RESET = 8'h00;
	// divide exponents per clock-select code, code 0 in the low nibble
	localparam logic [27:0] EVA_EXP = 28'hB975321;
	localparam logic [27:0] EVB_EXP = 28'hCA86421;
	localparam logic [3:0] HALF_EXP = 4'h1;
	localparam logic [3:0] ODA_EXP = 4'h3;
	localparam logic [3:0] ODB_EXP = 4'h4;
	localparam logic [2:0] CODE_EVENT = 3'h7;
endpackage
`default_nettype wire

// ---- qtm_top.sv ----
// quad 8-bit timer mode control with apb register access
// Overview of operation
// - even timers freeze while continue is 0, resume from held value at 1
// - even timers stop while clear-start is 0; rising to 1 clears then counts
// - timer 0 select 010..110 gives main tick over 2^3,5,7,9,11
// - timer 0 select 111 clocks from the external event pin
// - timer 2 select 010..110 gives main tick over 2^4,6,8,10,12
// - timer 1 mode register: cascade bit 6, select 3:2, continue 1, start 0
// - timer 3 polarity 0 makes duty active low, 1 active high
// - odd timers are 8-bit with cascade 0, 16-bit with cascade 1
// - timer 1 select: 00 main, 01 half, 10 eighth, 11 timer 0 clock
// - timer 3 select: 00 main, 01 half, 10 sixteenth, 11 timer 2 clock
// - even timers select 000 gives main over 2, 001 over 4
// - event-pin clocking counts on each rising edge of the pin
// - timer 3 pwm enable 1 drives the waveform, 0 disables it
//
// Added by the designer: the APB register port.
`default_nettype none
module qtm_top (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [13:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic i_sub_active,
	input wire logic i_sub_tick,
	input wire logic i_event_pin,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_count,
	output logic o_pwm
);
	typedef struct packed {
		logic [3:0][7:0] tm;
		logic [7:0] duty;
		logic [3:0][7:0] cnt;
		logic [11:0] pre;
		logic ev_prev;
		logic [3:0] st_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pwm;
	} qtm_state_t;

	qtm_state_t s;
	qtm_state_t next_s;
	logic base;
	logic ev_rise;
	logic [3:0] tick;
	logic [3:0] run;
	logic [3:0] st_rise;
	logic ovf0;
	logic ovf2;
	logic duty_on;

	function automatic logic div_tick(input logic b, input logic [11:0] p,
			input logic [3:0] e);
		logic [11:0] m;
		m = 12'((13'h0001 << e) - 13'h0001);
		return b && ((p & m) == m);
	endfunction

	function automatic logic [7:0] rd_mask(input logic [1:0] i);
		unique case (i)
			2'h1: return qtm_pkg::TM1_MASK;
			2'h3: return qtm_pkg::TM3_MASK;
			default: return qtm_pkg::EVEN_MASK;
		endcase
	endfunction

	always_comb begin
		logic [11:0] idx;
		logic hit;
		logic [31:0] rd;
		logic [2:0] c0;
		logic [2:0] c2;
		logic [1:0] c1;
		logic [1:0] c3;
		idx = i_paddr[13:2];
		hit = 1'b1;
		rd = 32'h0000_0000;
		next_s = s;

		// sub-active runs off the sub-oscillator tick, main-active every clock
		base = !i_sub_active || i_sub_tick;
		ev_rise = i_event_pin && !s.ev_prev;
		next_s.ev_prev = i_event_pin;
		if (base) begin
			next_s.pre = 12'(s.pre + 12'h001);
		end

		c0 = s.tm[0][qtm_pkg::CK_LSB +: 3];
		c2 = s.tm[2][qtm_pkg::CK_LSB +: 3];
		c1 = s.tm[1][qtm_pkg::CK_LSB +: 2];
		c3 = s.tm[3][qtm_pkg::CK_LSB +: 2];
		tick[0] = (c0 == qtm_pkg::CODE_EVENT) ? ev_rise
			: div_tick(base, s.pre, qtm_pkg::EVA_EXP[4*c0 +: 4]);
		// reserved code yields no clock at all
		tick[2] = (c2 == qtm_pkg::CODE_EVENT) ? 1'b0
			: div_tick(base, s.pre, qtm_pkg::EVB_EXP[4*c2 +: 4]);
		for (int i = 0; i < 4; i++) begin
			run[i] = s.tm[i][qtm_pkg::ST_BIT] && s.tm[i][qtm_pkg::CN_BIT];
			st_rise[i] = s.tm[i][qtm_pkg::ST_BIT] && !s.st_prev[i];
			next_s.st_prev[i] = s.tm[i][qtm_pkg::ST_BIT];
		end

		// carry when the lower byte is at FF on a running tick, even if a fresh start clears it
		ovf0 = tick[0] && run[0] && (s.cnt[0] == 8'hFF);
		ovf2 = tick[2] && run[2] && (s.cnt[2] == 8'hFF);
		unique case (c1)
			2'h0: tick[1] = base;
			2'h1: tick[1] = div_tick(base, s.pre, qtm_pkg::HALF_EXP);
			2'h2: tick[1] = div_tick(base, s.pre, qtm_pkg::ODA_EXP);
			2'h3: tick[1] = tick[0];
		endcase
		unique case (c3)
			2'h0: tick[3] = base;
			2'h1: tick[3] = div_tick(base, s.pre, qtm_pkg::HALF_EXP);
			2'h2: tick[3] = div_tick(base, s.pre, qtm_pkg::ODB_EXP);
			2'h3: tick[3] = tick[2];
		endcase

		// upper byte advances only on the lower byte's carry
		if (s.tm[1][qtm_pkg::CAS_BIT]) begin
			tick[1] = ovf0;
		end
		if (s.tm[3][qtm_pkg::CAS_BIT]) begin
			tick[3] = ovf2;
		end
		for (int i = 0; i < 4; i++) begin
			// a fresh start clears first; a start already set only resumes
			if (st_rise[i]) begin
				next_s.cnt[i] = 8'h00;
			end else if (tick[i] && run[i]) begin
				next_s.cnt[i] = 8'(s.cnt[i] + 8'h01);
			end
		end

		// a duty of zero keeps the duty portion off for the whole period
		duty_on = s.cnt[3] < s.duty;
		if (!s.tm[3][qtm_pkg::PWMEN_BIT]) begin
			next_s.pwm = 1'b0;
		end else if (s.tm[3][qtm_pkg::POL_BIT]) begin
			next_s.pwm = duty_on;
		end else begin
			next_s.pwm = !duty_on;
		end

		// apb decode; one wait state so read data comes from a register
		unique case (idx)
			qtm_pkg::IDX_TM0: rd = {24'h0, s.tm[0]};
			qtm_pkg::IDX_TM1: rd = {24'h0, s.tm[1]};
			qtm_pkg::IDX_TM2: rd = {24'h0, s.tm[2]};
			qtm_pkg::IDX_TM3: rd = {24'h0, s.tm[3]};
			qtm_pkg::IDX_CNT0: rd = {24'h0, s.cnt[0]};
			qtm_pkg::IDX_CNT0 + 12'h001: rd = {24'h0, s.cnt[1]};
			qtm_pkg::IDX_CNT0 + 12'h002: rd = {24'h0, s.cnt[2]};
			qtm_pkg::IDX_CNT0 + 12'h003: rd = {24'h0, s.cnt[3]};
			qtm_pkg::IDX_DUTY: rd = {24'h0, s.duty};
			default: hit = 1'b0;
		endcase

		next_s.pready = i_psel && i_penable && !s.pready;
		next_s.pslverr = next_s.pready && !hit;
		if (next_s.pready) begin
			next_s.prdata = i_pwrite ? 32'h0000_0000 : rd;
		end

		// commit on the edge where the master sees ready, never earlier
		if (i_psel && i_penable && s.pready && i_pwrite && hit) begin
			for (int i = 0; i < 4; i++) begin
				if (idx == qtm_pkg::IDX_TM0 + 12'(i == 3 ? 8 : i * 2 + (i == 2 ? 2 : 0))) begin
					next_s.tm[i] = i_pwdata[7:0] & rd_mask(2'(i));
				end
			end
			if (idx == qtm_pkg::IDX_DUTY) begin
				next_s.duty = i_pwdata[7:0];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '0;
			s.tm <= {4{qtm_pkg::REG_RESET}};
		end else begin
			s <= next_s;
		end
	end

	assign o_prdata = s.prdata;
	assign o_pready = s.pready;
	assign o_pslverr = s.pslverr;
	assign o_count = s.cnt;
	assign o_pwm = s.pwm;

	function automatic logic c0_is(input logic [2:0] v);
		return s.tm[0][qtm_pkg::CK_LSB +: 3] == v;
	endfunction

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// a timer 0 count step that no fresh start overrides
	sequence t0_step;
		tick[0] && run[0] && !st_rise[0];
	endsequence

	// carry from the lower byte with the upper byte running
	sequence t1_carry;
		s.tm[1][qtm_pkg::CAS_BIT] && ovf0 && run[1] && !st_rise[1];
	endsequence

	// first access-phase cycle of an apb transfer
	sequence apb_first;
		i_psel && i_penable && !s.pready;
	endsequence

	a_pause_freeze: assert property (!s.tm[0][qtm_pkg::CN_BIT] && !st_rise[0]
		|=> $stable(s.cnt[0])) else $error("paused timer 0 moved");

	a_start_clear: assert property (st_rise[2] |=> s.cnt[2] == 8'h00)
		else $error("start did not clear timer 2");

	a_t0_div8: assert property (c0_is(3'h2) && base && s.pre[2:0] == 3'h7
		&& run[0] && !st_rise[0] |=> s.cnt[0] == 8'($past(s.cnt[0]) + 8'h01))
		else $error("timer 0 divide by 8 missed");

	a_t0_event: assert property (c0_is(3'h7) && ev_rise ##0 t0_step
		|=> s.cnt[0] == 8'($past(s.cnt[0]) + 8'h01))
		else $error("event edge not counted");

	a_t2_div16: assert property (s.tm[2][4:2] == 3'h2 && tick[2]
		|-> base && s.pre[3:0] == 4'hF) else $error("timer 2 divide wrong");

	a_tm1_layout: assert property ((s.tm[1] & ~qtm_pkg::TM1_MASK) == 8'h00)
		else $error("timer 1 reserved bits set");

	a_pwm_polarity: assert property (s.tm[3][qtm_pkg::PWMEN_BIT] ##1
		$stable(s.tm[3]) |-> o_pwm == ($past(duty_on) ~^ s.tm[3][qtm_pkg::POL_BIT]))
		else $error("pwm level wrong");

	a_cascade_carry: assert property (s.tm[1][qtm_pkg::CAS_BIT] && !ovf0
		&& !st_rise[1] |=> $stable(s.cnt[1])) else $error("upper byte moved");

	a_t1_undiv: assert property (s.tm[1][6:2] == 5'h00 && base && run[1]
		&& !st_rise[1] |=> s.cnt[1] == 8'($past(s.cnt[1]) + 8'h01))
		else $error("timer 1 main tick missed");

	a_t0_clear: assert property (st_rise[0] |=> s.cnt[0] == 8'h00)
		else $error("start did not clear timer 0");

	a_t2_pause: assert property (!s.tm[2][qtm_pkg::CN_BIT] && !st_rise[2]
		|=> $stable(s.cnt[2])) else $error("paused timer 2 moved");

	a_t2_reserved: assert property (s.tm[2][4:2] == 3'h7 |-> !tick[2])
		else $error("reserved select clocked timer 2");

	a_t0_div4: assert property (c0_is(3'h1) && tick[0]
		|-> base && s.pre[1:0] == 2'h3) else $error("timer 0 divide by 4 wrong");

	a_t2_div2: assert property (s.tm[2][4:2] == 3'h0 && tick[2]
		|-> base && s.pre[0]) else $error("timer 2 divide by 2 wrong");

	a_t1_half: assert property (s.tm[1][6:2] == 5'h01 && tick[1]
		|-> base && s.pre[0]) else $error("timer 1 half rate wrong");

	a_t1_eighth: assert property (s.tm[1][6:2] == 5'h02 && tick[1]
		|-> base && s.pre[2:0] == 3'h7) else $error("timer 1 eighth rate wrong");

	a_t3_div16: assert property (!s.tm[3][qtm_pkg::CAS_BIT] && s.tm[3][3:2] == 2'h2
		&& tick[3] |-> base && s.pre[3:0] == 4'hF) else $error("timer 3 divide wrong");

	a_t1_chain: assert property (s.tm[1][6:2] == 5'h03 |-> tick[1] == tick[0])
		else $error("timer 1 chain clock wrong");

	a_t3_chain: assert property (!s.tm[3][qtm_pkg::CAS_BIT] && s.tm[3][3:2] == 2'h3
		|-> tick[3] == tick[2]) else $error("timer 3 chain clock wrong");

	a_t3_carry: assert property (s.tm[3][qtm_pkg::CAS_BIT] && !ovf2 && !st_rise[3]
		|=> $stable(s.cnt[3])) else $error("timer 3 upper byte moved");

	a_carry_step: assert property (t1_carry
		|=> s.cnt[1] == 8'($past(s.cnt[1]) + 8'h01)) else $error("carry not counted");

	a_event_only: assert property (c0_is(3'h7) && !ev_rise && !st_rise[0]
		|=> $stable(s.cnt[0])) else $error("timer 0 moved without event edge");

	a_pwm_off: assert property (!s.tm[3][qtm_pkg::PWMEN_BIT] |=> !o_pwm)
		else $error("disabled pwm output high");

	a_sub_hold: assert property (s.tm[1][6:2] == 5'h00 && i_sub_active && !i_sub_tick
		&& !st_rise[1] |=> $stable(s.cnt[1])) else $error("timer 1 moved between sub ticks");

	a_ready_wait: assert property (apb_first |=> o_pready)
		else $error("access not answered");

	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");

	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
endmodule
`default_nettype wire

// ---- qtm_tb.sv ----
// self-checking apb bench for the quad timer mode-control block
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ns;
logic i_clock, i_rst, psel, pen, pwr, sub, stk, ev, pready, pslverr, pwm, err;
logic [13:0] paddr;
logic [31:0] pwdata, prdata, cnt, rd;
logic [7:0] a;
logic [2:0] sp;
int fails, n_compared;
qtm_top qtm_top_i (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
	.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_sub_active(sub),
	.i_sub_tick(stk), .i_event_pin(ev), .o_prdata(prdata), .o_pready(pready),
	.o_pslverr(pslverr), .o_count(cnt), .o_pwm(pwm));
initial begin
	i_clock = 0;
	forever #5 i_clock = ~i_clock;
end
// sub-oscillator tick, one pulse every eight clocks
always @(posedge i_clock) begin
	if (i_rst) begin
		sp <= 3'h0;
		stk <= 1'b0;
	end else begin
		sp <= sp + 3'h1;
		stk <= (sp == 3'h3);
	end
end
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	n_compared++;
	if (seen !== exp) begin
		fails++;
		$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
	int n;
	@(posedge i_clock);
	psel <= 1'b1;
	pwr <= w;
	paddr <= {idx, 2'b00};
	pwdata <= {24'h0, d};
	@(posedge i_clock);
	pen <= 1'b1;
	n = 0;
	do begin
		@(posedge i_clock);
		n++;
	end while (pready !== 1'b1 && n < 50);
	if (pready !== 1'b1) begin
		fails++;
	end
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	pen <= 1'b0;
endtask
// delta over a whole number of prescaler periods does not depend on its phase
task automatic rate(input logic [11:0] idx, input logic [7:0] v, input int sh, input int win,
	input logic [7:0] dl);
	apb(1'b1, idx, v);
	repeat (4) @(posedge i_clock);
	a = cnt[sh+:8];
	repeat (win) @(posedge i_clock);
	chk({24'h0, 8'(cnt[sh+:8] - a)}, {24'h0, dl});
endtask
task automatic pw(input logic [7:0] v, input logic exp);
	apb(1'b1, qtm_pkg::IDX_TM3, v);
	repeat (3) @(posedge i_clock);
	chk({31'h0, pwm}, {31'h0, exp});
endtask
task automatic finish_test;
	$display("compared %0d, wrong %0d", n_compared, fails);
	if (fails == 0 && n_compared > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask
initial begin
	repeat (80000) @(posedge i_clock);
	fails++;
	finish_test;
end
initial begin
	{psel, pen, pwr, sub, ev, paddr, pwdata} = '0;
	fails = 0;
	n_compared = 0;
	i_rst = 1'b1;
	repeat (10) @(posedge i_clock);
	i_rst <= 1'b0;
	apb(1'b0, qtm_pkg::IDX_TM1, 8'h00);
	chk(rd, 32'h0);
	apb(1'b1, qtm_pkg::IDX_TM1, 8'hFF);
	apb(1'b0, qtm_pkg::IDX_TM1, 8'h00);
	chk(rd, 32'h4F);
	apb(1'b0, 12'h0A0, 8'h00);
	chk({31'h0, err}, 32'h1);
	$display("test registers done");
	for (int c = 0; c < 7; c++) begin
		rate(qtm_pkg::IDX_TM0, 8'(c * 4 + 3), 0, 4 << (c < 2 ? c + 1 : 2 * c - 1), 8'h4);
		rate(qtm_pkg::IDX_TM2, 8'(c * 4 + 3), 16, 4 << (c < 2 ? c + 1 : 2 * c), 8'h4);
	end
	for (int c = 0; c < 3; c++) begin
		rate(qtm_pkg::IDX_TM1, 8'(c * 4 + 3), 8, 16 << (c == 2 ? 3 : c), 8'h10);
		rate(qtm_pkg::IDX_TM3, 8'(c * 4 + 3), 24, 16 << (c == 2 ? 4 : c), 8'h10);
	end
	apb(1'b1, qtm_pkg::IDX_TM0, 8'h03);
	rate(qtm_pkg::IDX_TM1, 8'h0F, 8, 32, 8'h10);
	apb(1'b1, qtm_pkg::IDX_TM2, 8'h03);
	rate(qtm_pkg::IDX_TM3, 8'h0F, 24, 32, 8'h10);
	$display("test prescalers done");
	rate(qtm_pkg::IDX_TM1, 8'h43, 8, 2048, 8'h4);
	rate(qtm_pkg::IDX_TM3, 8'h43, 24, 2048, 8'h4);
	rate(qtm_pkg::IDX_TM0, 8'h01, 0, 20, 8'h0);
	rate(qtm_pkg::IDX_TM0, 8'h03, 0, 20, 8'hA);
	rate(qtm_pkg::IDX_TM0, 8'h02, 0, 20, 8'h0);
	apb(1'b1, qtm_pkg::IDX_TM0, 8'h03);
	repeat (3) @(posedge i_clock);
	chk({31'h0, cnt[7:0] < 8'h3}, 32'h1);
	$display("test run control done");
	apb(1'b1, qtm_pkg::IDX_TM0, 8'h1F);
	repeat (3) @(posedge i_clock);
	a = cnt[7:0];
	repeat (5) begin
		ev <= 1'b1;
		repeat (3) @(posedge i_clock);
		ev <= 1'b0;
		repeat (3) @(posedge i_clock);
	end
	chk({24'h0, 8'(cnt[7:0] - a)}, 32'h5);
	apb(1'b1, qtm_pkg::IDX_DUTY, 8'h00);
	pw(8'h20, 1'b1);
	pw(8'hA0, 1'b0);
	pw(8'h00, 1'b0);
	sub <= 1'b1;
	rate(qtm_pkg::IDX_TM1, 8'h03, 8, 64, 8'h8);
	$display("test event pwm sub done");
	finish_test;
end
endmodule
`default_nettype wire
